/* File: bench/pcct_card_model.sv */
// Card-side model: measures each phase of a card cycle at the socket.
// Assumes strobes and busy change just after the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module pcct_card_model (
    input  wire logic                   clk,         // Bench clock
    input  wire logic                   resetn,      // Async reset, low
    input  wire logic                   cmd_start,   // Clears the counts
    input  wire pcct_pkg::pcct_strobe_t card_strobe, // Socket strobes
    input  wire logic                   cyc_busy,    // Cycle in progress
    output var  logic [15:0]            setup_cnt,   // Cycles before strobe
    output var  logic [15:0]            act_cnt,     // Cycles strobe low
    output var  logic [15:0]            rec_cnt,     // Cycles after strobe
    output var  pcct_pkg::pcct_strobe_t low_seen     // Strobe pattern seen
);
    // Phase counters; a plain card drives nothing back, so only time is seen
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            setup_cnt <= '0;
            act_cnt   <= '0;
            rec_cnt   <= '0;
            low_seen  <= 4'hF;
        end
        else if (cmd_start)
        begin
            setup_cnt <= '0;
            act_cnt   <= '0;
            rec_cnt   <= '0;
            low_seen  <= 4'hF;
        end
        else if (card_strobe != 4'hF)
        begin
            act_cnt  <= act_cnt + 16'h0001;
            low_seen <= card_strobe;
        end
        else if (cyc_busy && act_cnt == 16'h0000)
            setup_cnt <= setup_cnt + 16'h0001;
        else if (cyc_busy)
            rec_cnt <= rec_cnt + 16'h0001;
    end
endmodule
`default_nettype wire

/* File: bench/tb_pcct_timing.sv */
// Self-checking bench for the card cycle timing generator.
// Assumes one 40 MHz clock and the card model on the socket side.
`timescale 1ns/1ps
`default_nettype none
`include "pcct_params.svh"
module tb_pcct_timing;
    logic                   clk, resetn, cmd_start, cmd_window, cyc_busy;
    logic [7:0]             awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp;
    logic                   awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready;
    pcct_pkg::pcct_kind_t   cmd_kind;
    pcct_pkg::pcct_strobe_t card_strobe, low_seen;
    logic [15:0]            setup_cnt, act_cnt, rec_cnt;
    int                     miscompares, check_count;
    int                     cycles = 0;
    int                     wts[4] = '{1, 16, 256, 8192};

    pcct_timing u_pcct_timing (.clk(clk), .resetn(resetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cmd_start(cmd_start),
        .cmd_kind(cmd_kind), .cmd_window(cmd_window),
        .card_strobe(card_strobe), .cyc_busy(cyc_busy));

    pcct_card_model u_pcct_card_model (.clk(clk), .resetn(resetn),
        .cmd_start(cmd_start), .card_strobe(card_strobe), .cyc_busy(cyc_busy),
        .setup_cnt(setup_cnt), .act_cnt(act_cnt), .rec_cnt(rec_cnt),
        .low_seen(low_seen));

    // 25 ns clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] val,
                      input logic [1:0] resp);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        check({30'h0, bresp}, {30'h0, resp});
    endtask

    // Read and compare data and response
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp,
                          input logic [1:0] resp);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        check(rdata, {24'h0, exp});
        check({30'h0, rresp}, {30'h0, resp});
    endtask

    // One card cycle; phase lengths come from the card model's counters
    task automatic cyc(input logic [1:0] k, input logic w, input int s, c, r);
        cmd_start  <= 1'b1;
        cmd_kind   <= pcct_pkg::pcct_kind_t'(k);
        cmd_window <= w;
        @(posedge clk);
        cmd_start <= 1'b0;
        do @(negedge clk); while (cyc_busy !== 1'b0);
        check({16'h0, setup_cnt}, 32'(s));
        check({16'h0, act_cnt}, 32'(c));
        check({16'h0, rec_cnt}, 32'(r));
        check({28'h0, low_seen}, {28'h0, 4'hF ^ (4'h8 >> k)});
        @(posedge clk);
    endtask

    // Hang guard: longest test is well under this
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        {resetn, cmd_start, cmd_window, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata} = '0;
        cmd_kind = pcct_pkg::PCCT_K_OE;
        wstrb = 4'hF;
        miscompares = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(`PCCT_IDX_ACT0, 8'h06, `PCCT_RESP_OKAY);
        rd_chk(`PCCT_IDX_ACT1, 8'h0F, `PCCT_RESP_OKAY);
        rd_chk(6'h10, 8'h00, `PCCT_RESP_SLVERR);
        wr(6'h10, 8'h5A, `PCCT_RESP_SLVERR);
        cyc(2'd0, 1'b0, 2, 7, 4);
        // Every weight, each with a different strobe
        for (int i = 0; i < 4; i++)
        begin
            wr(`PCCT_IDX_ACT0, {i[1:0], 6'h01}, `PCCT_RESP_OKAY);
            cyc(i[1:0], 1'b0, 2, wts[i] + 1, 4);
        end
        wr(`PCCT_IDX_ACT0, 8'h00, `PCCT_RESP_OKAY);
        wr(`PCCT_IDX_SETUP0, 8'h3F, `PCCT_RESP_OKAY);
        wr(`PCCT_IDX_RECOV0, 8'h02, `PCCT_RESP_OKAY);
        rd_chk(`PCCT_IDX_SETUP0, 8'h3F, `PCCT_RESP_OKAY);
        cyc(2'd1, 1'b0, 64, 1, 3);
        // Set selection per window
        wr(`PCCT_IDX_CTRL, 8'h08, `PCCT_RESP_OKAY);
        cyc(2'd2, 1'b0, 2, 16, 4);
        wr(`PCCT_IDX_CTRL, 8'h80, `PCCT_RESP_OKAY);
        cyc(2'd3, 1'b1, 2, 16, 4);
        cyc(2'd3, 1'b0, 64, 1, 3);
        rd_chk(`PCCT_IDX_STAT, 8'h00, `PCCT_RESP_OKAY);
        stop_test();
    end
endmodule
`default_nettype wire

/* File: hw/pcct_params.svh */
// Constants for the card cycle timing generator: register indices,
// reset values, field positions and bus response codes.
// Assumes it is included by the package user files by its bare name.
`ifndef PCCT_PARAMS_SVH
`define PCCT_PARAMS_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PCCT_IDX_CTRL     6'h00
`define PCCT_IDX_STAT     6'h01
`define PCCT_IDX_SETUP0   6'h3A
`define PCCT_IDX_ACT0     6'h3B
`define PCCT_IDX_RECOV0   6'h3C
`define PCCT_IDX_SETUP1   6'h3D
`define PCCT_IDX_ACT1     6'h3E
`define PCCT_IDX_RECOV1   6'h3F
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCCT_RST_CTRL     8'h00
`define PCCT_RST_SETUP    8'h01
`define PCCT_RST_ACT0     8'h06
`define PCCT_RST_ACT1     8'h0F
`define PCCT_RST_RECOV    8'h03
// ----------------------------------------------------------------------
// Field positions and prescale shifts (weights 16, 256, 8192)
// ----------------------------------------------------------------------
`define PCCT_CTRL_SEL0    3
`define PCCT_CTRL_SEL1    7
`define PCCT_SH_W16       4
`define PCCT_SH_W256      8
`define PCCT_SH_W8192     13
// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define PCCT_RESP_OKAY    2'h0
`define PCCT_RESP_SLVERR  2'h2
`endif

/* File: hw/pcct_pkg.sv */
// Types shared by the card cycle timing generator and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package pcct_pkg;
    // One timing register: prescale select over a 6-bit multiplier
    typedef struct packed {
        logic [1:0] prescale_weight;
        logic [5:0] multiplier_value;
    } pcct_timing_t;

    // Card command strobes, all active low
    typedef struct packed {
        logic oe_n;
        logic we_n;
        logic iord_n;
        logic iowr_n;
    } pcct_strobe_t;

    typedef enum logic [1:0] {PCCT_K_OE, PCCT_K_WE, PCCT_K_IORD, PCCT_K_IOWR} pcct_kind_t;

    typedef enum logic [1:0] {PCCT_IDLE, PCCT_SETUP, PCCT_ACTIVE, PCCT_RECOV} pcct_state_t;
endpackage

/* File: hw/pcct_timing.sv */
// Card cycle timing generator with its AXI4-Lite register slave.
// Assumes one 40 MHz clock, an AXI4-Lite master with one access of each
// kind in flight, and a cycle requester on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pcct_params.svh"

module pcct_timing (
    input  wire logic                  clk,         // 40 MHz clock
    input  wire logic                  resetn,      // Async reset, low
    input  wire logic [7:0]            awaddr,      // Write address
    input  wire logic [2:0]            awprot,      // Unused
    input  wire logic                  awvalid,     // Write address valid
    output var  logic                  awready,     // Write address ready
    input  wire logic [31:0]           wdata,       // Write data
    input  wire logic [3:0]            wstrb,       // Byte enables
    input  wire logic                  wvalid,      // Write data valid
    output var  logic                  wready,      // Write data ready
    output var  logic [1:0]            bresp,       // Write response
    output var  logic                  bvalid,      // Write response valid
    input  wire logic                  bready,      // Write response ready
    input  wire logic [7:0]            araddr,      // Read address
    input  wire logic [2:0]            arprot,      // Unused
    input  wire logic                  arvalid,     // Read address valid
    output var  logic                  arready,     // Read address ready
    output var  logic [31:0]           rdata,       // Read data
    output var  logic [1:0]            rresp,       // Read response
    output var  logic                  rvalid,      // Read data valid
    input  wire logic                  rready,      // Read data ready
    input  wire logic                  cmd_start,   // Start a card cycle
    input  wire pcct_pkg::pcct_kind_t  cmd_kind,    // Which strobe
    input  wire logic                  cmd_window,  // I/O window 0 or 1
    output var  pcct_pkg::pcct_strobe_t card_strobe, // Card strobes
    output var  logic                  cyc_busy     // Cycle in progress
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pcct_pkg::pcct_timing_t setup_q [2];
    pcct_pkg::pcct_timing_t setup_d [2];
    pcct_pkg::pcct_timing_t act_q   [2];
    pcct_pkg::pcct_timing_t act_d   [2];
    pcct_pkg::pcct_timing_t rec_q   [2];
    pcct_pkg::pcct_timing_t rec_d   [2];
    logic [7:0]             ctrl_q, ctrl_d;
    logic                   aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [5:0]             aw_idx_q, aw_idx_d;
    logic [7:0]             w_data_q, w_data_d;
    logic                   w_lane_q, w_lane_d;
    logic                   awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]             bresp_d, rresp_d;
    logic [31:0]            rdata_d;
    logic                   wr_go;
    pcct_pkg::pcct_state_t  state_q, state_d;
    logic [19:0]            cnt_q, cnt_d;
    logic                   set_q, set_d;
    pcct_pkg::pcct_kind_t   kind_q, kind_d;
    pcct_pkg::pcct_strobe_t strb_d;
    logic                   busy_d;

    // Phase length in cycles minus one: weight times multiplier
    function automatic logic [19:0] pcct_load(input pcct_pkg::pcct_timing_t t);
        logic [19:0] m;
        m = {14'h0000, t.multiplier_value};
        case (t.prescale_weight)
            2'h0:    pcct_load = m;
            2'h1:    pcct_load = m << `PCCT_SH_W16;
            2'h2:    pcct_load = m << `PCCT_SH_W256;
            default: pcct_load = m << `PCCT_SH_W8192;
        endcase
    endfunction

    // Indices that answer OKAY
    function automatic logic pcct_mapped(input logic [5:0] i);
        case (i)
            `PCCT_IDX_CTRL, `PCCT_IDX_STAT, `PCCT_IDX_SETUP0, `PCCT_IDX_ACT0,
            `PCCT_IDX_RECOV0, `PCCT_IDX_SETUP1, `PCCT_IDX_ACT1,
            `PCCT_IDX_RECOV1: pcct_mapped = 1'b1;
            default:          pcct_mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    // Address and data are caught separately so either may come first
    always_comb
    begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        aw_idx_d  = aw_idx_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid;
        bresp_d   = bresp;
        rvalid_d  = rvalid;
        rresp_d   = rresp;
        rdata_d   = rdata;
        wr_go     = aw_full_q && w_full_q && !bvalid;
        if (bvalid && bready)
            bvalid_d = 1'b0;
        if (wr_go)
        begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = pcct_mapped(aw_idx_q) ? `PCCT_RESP_OKAY : `PCCT_RESP_SLVERR;
        end
        if (awvalid && awready)
        begin
            aw_full_d = 1'b1;
            aw_idx_d  = awaddr[7:2];
        end
        if (wvalid && wready)
        begin
            w_full_d = 1'b1;
            w_data_d = wdata[7:0];
            w_lane_d = wstrb[0];
        end
        if (rvalid && rready)
            rvalid_d = 1'b0;
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = pcct_mapped(araddr[7:2]) ? `PCCT_RESP_OKAY : `PCCT_RESP_SLVERR;
            case (araddr[7:2])
                `PCCT_IDX_CTRL:   rdata_d = {24'h000000, ctrl_q};
                `PCCT_IDX_STAT:   rdata_d = {30'h00000000, ~&card_strobe, cyc_busy};
                `PCCT_IDX_SETUP0: rdata_d = {24'h000000, setup_q[0]};
                `PCCT_IDX_ACT0:   rdata_d = {24'h000000, act_q[0]};
                `PCCT_IDX_RECOV0: rdata_d = {24'h000000, rec_q[0]};
                `PCCT_IDX_SETUP1: rdata_d = {24'h000000, setup_q[1]};
                `PCCT_IDX_ACT1:   rdata_d = {24'h000000, act_q[1]};
                `PCCT_IDX_RECOV1: rdata_d = {24'h000000, rec_q[1]};
                default:          rdata_d = 32'h00000000;
            endcase
        end
        // Ready only while the holding slot is free
        awready_d = !aw_full_d;
        wready_d  = !w_full_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_idx_q  <= 6'h00;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            arready   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `PCCT_RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= `PCCT_RESP_OKAY;
            rdata     <= 32'h00000000;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            aw_idx_q  <= aw_idx_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            awready   <= awready_d;
            wready    <= wready_d;
            arready   <= arready_d;
            bvalid    <= bvalid_d;
            bresp     <= bresp_d;
            rvalid    <= rvalid_d;
            rresp     <= rresp_d;
            rdata     <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Writes land at once; a change mid cycle shows at the next phase start
    always_comb
    begin
        setup_d = setup_q;
        act_d   = act_q;
        rec_d   = rec_q;
        ctrl_d  = ctrl_q;
        if (wr_go && w_lane_q)
        begin
            case (aw_idx_q)
                `PCCT_IDX_CTRL:   ctrl_d     = w_data_q;
                `PCCT_IDX_SETUP0: setup_d[0] = w_data_q;
                `PCCT_IDX_ACT0:   act_d[0]   = w_data_q;
                `PCCT_IDX_RECOV0: rec_d[0]   = w_data_q;
                `PCCT_IDX_SETUP1: setup_d[1] = w_data_q;
                `PCCT_IDX_ACT1:   act_d[1]   = w_data_q;
                `PCCT_IDX_RECOV1: rec_d[1]   = w_data_q;
                default:          ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q     <= `PCCT_RST_CTRL;
            setup_q[0] <= `PCCT_RST_SETUP;
            setup_q[1] <= `PCCT_RST_SETUP;
            act_q[0]   <= `PCCT_RST_ACT0;
            act_q[1]   <= `PCCT_RST_ACT1;
            rec_q[0]   <= `PCCT_RST_RECOV;
            rec_q[1]   <= `PCCT_RST_RECOV;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            setup_q <= setup_d;
            act_q   <= act_d;
            rec_q   <= rec_d;
        end
    end

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    // A count of N+1 is loaded as N and run down to zero, so each phase
    // spans whole clock periods; requests while busy are ignored
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        set_d   = set_q;
        kind_d  = kind_q;
        case (state_q)
            pcct_pkg::PCCT_IDLE:
                if (cmd_start)
                begin
                    set_d   = cmd_window ? ctrl_q[`PCCT_CTRL_SEL1]
                                         : ctrl_q[`PCCT_CTRL_SEL0];
                    kind_d  = cmd_kind;
                    state_d = pcct_pkg::PCCT_SETUP;
                    cnt_d   = pcct_load(setup_q[set_d]);
                end
            pcct_pkg::PCCT_SETUP:
                if (cnt_q == 20'h00000)
                begin
                    state_d = pcct_pkg::PCCT_ACTIVE;
                    cnt_d   = pcct_load(act_q[set_q]);
                end
                else
                    cnt_d = cnt_q - 20'h00001;
            pcct_pkg::PCCT_ACTIVE:
                if (cnt_q == 20'h00000)
                begin
                    state_d = pcct_pkg::PCCT_RECOV;
                    cnt_d   = pcct_load(rec_q[set_q]);
                end
                else
                    cnt_d = cnt_q - 20'h00001;
            pcct_pkg::PCCT_RECOV:
                if (cnt_q == 20'h00000)
                    state_d = pcct_pkg::PCCT_IDLE;
                else
                    cnt_d = cnt_q - 20'h00001;
            default:
                state_d = pcct_pkg::PCCT_IDLE;
        endcase
        // Strobe low only in the active phase, for the requested kind
        strb_d = 4'hF;
        if (state_d == pcct_pkg::PCCT_ACTIVE)
        begin
            case (kind_d)
                pcct_pkg::PCCT_K_OE:   strb_d.oe_n   = 1'b0;
                pcct_pkg::PCCT_K_WE:   strb_d.we_n   = 1'b0;
                pcct_pkg::PCCT_K_IORD: strb_d.iord_n = 1'b0;
                default:               strb_d.iowr_n = 1'b0;
            endcase
        end
        busy_d = (state_d != pcct_pkg::PCCT_IDLE);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q     <= pcct_pkg::PCCT_IDLE;
            cnt_q       <= 20'h00000;
            set_q       <= 1'b0;
            kind_q      <= pcct_pkg::PCCT_K_OE;
            card_strobe <= 4'hF;
            cyc_busy    <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            set_q       <= set_d;
            kind_q      <= kind_d;
            card_strobe <= strb_d;
            cyc_busy    <= busy_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Helpers: cycles spent in a phase, its loaded count, write history
    logic [19:0] len_q, len_d, ldv_q, ldv_d;
    logic        acted_q, acted_d;

    always_comb
    begin
        len_d   = (state_d != state_q) ? 20'h00000 : len_q + 20'h00001;
        ldv_d   = (state_d != state_q) ? cnt_d : ldv_q;
        acted_d = acted_q || (wr_go && (aw_idx_q == `PCCT_IDX_ACT0 ||
                                        aw_idx_q == `PCCT_IDX_ACT1));
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            len_q   <= 20'h00000;
            ldv_q   <= 20'h00000;
            acted_q <= 1'b0;
        end
        else
        begin
            len_q   <= len_d;
            ldv_q   <= ldv_d;
            acted_q <= acted_d;
        end
    end

    a_set_select: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_IDLE && cmd_start) |=>
        set_q == ($past(cmd_window) ? $past(ctrl_q[`PCCT_CTRL_SEL1])
                                    : $past(ctrl_q[`PCCT_CTRL_SEL0])))
        else $error("timing set not taken from window select");
    a_write_immediate: assert property (@(posedge clk) disable iff (!resetn)
        (wr_go && w_lane_q && aw_idx_q == `PCCT_IDX_ACT0) |=> act_q[0] == $past(w_data_q))
        else $error("timing write did not take effect");
    a_setup_length: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_SETUP && state_d != state_q) |->
        len_q == pcct_load(setup_q[set_q]) || $changed(setup_q[set_q]))
        else $error("setup phase length wrong");
    a_weight_8192: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_ACTIVE && $past(state_q) == pcct_pkg::PCCT_SETUP &&
         $past(act_q[set_q].prescale_weight) == 2'h3) |->
        cnt_q == {1'b0, $past(act_q[set_q].multiplier_value), 13'h0000})
        else $error("prescale weight 8192 wrong");
    a_mult_range: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_ACTIVE && $past(state_q) == pcct_pkg::PCCT_SETUP &&
         $past(act_q[set_q].prescale_weight) == 2'h0) |->
        cnt_q == {14'h0000, $past(act_q[set_q].multiplier_value)})
        else $error("multiplier not loaded as is");
    a_active_length: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_ACTIVE && state_d != state_q) |-> len_q == ldv_q)
        else $error("active phase length wrong");
    a_strobe_phase: assert property (@(posedge clk) disable iff (!resetn)
        (&card_strobe) != (state_q == pcct_pkg::PCCT_ACTIVE))
        else $error("strobe not tied to active phase");
    a_reset_counts: assert property (@(posedge clk) disable iff (!resetn)
        !acted_q |-> (act_q[0] == `PCCT_RST_ACT0 && act_q[1] == `PCCT_RST_ACT1))
        else $error("command count reset value wrong");
    a_min_phase: assert property (@(posedge clk) disable iff (!resetn)
        (state_q != pcct_pkg::PCCT_IDLE && state_d != state_q) |-> cnt_q == 20'h00000)
        else $error("phase left before its count ran out");
    a_recov_length: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_RECOV && state_d != state_q) |-> len_q == ldv_q)
        else $error("recovery phase length wrong");
    a_phase_order: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == pcct_pkg::PCCT_ACTIVE && state_d != state_q) |=>
        state_q == pcct_pkg::PCCT_RECOV && card_strobe == 4'hF)
        else $error("recovery did not follow active");

endmodule
`default_nettype wire
